/* File: rtl/fwp_host.sv */
`timescale 1ns/1ps
// Operation
// - Write starts only with chip select and write strobe low, output enable high.
// - Reset pin at high voltage gives temporary unprotect; host holds it throughout.
// - To protect a sector, host holds high voltage on address bit 9 and output enable.
// - Chip unprotect: high voltage on output enable and addr_bit_9, select low, addr_bit_6 high.
// - Host should protect all sectors before starting chip unprotect; OP_UNPROTECT does not, and leaves that to the caller.
module fwp_host (
  input  wire logic                        CLOCK_I,
  input  wire logic                        RST_I,
  input  wire logic                        REQ_VALID_I,
  input  wire fwp_pkg::fwp_req_t           REQ_I,
  output logic                             REQ_READY_O,
  output logic                             RSP_VALID_O,
  output logic [fwp_pkg::DATA_W-1:0]       RSP_DATA_O,
  output logic                             RSP_PROTECTED_O,
  input  wire logic                        TEMP_UNPROTECT_I,
  output logic                             FLASH_CE_N_O,
  output logic                             FLASH_OE_N_O,
  output logic                             FLASH_WE_N_O,
  output logic                             FLASH_OE_HV_O,
  output logic                             FLASH_ADDR9_HV_O,
  output logic                             FLASH_RESET_HV_O,
  output logic [fwp_pkg::ADDR_W-1:0]       FLASH_ADDR_O,
  input  wire logic [fwp_pkg::DATA_W-1:0]  FLASH_DQ_I,
  output logic [fwp_pkg::DATA_W-1:0]       FLASH_DQ_O,
  output logic                             FLASH_DQ_OE_O
);
  import fwp_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  fwp_ctx_t r_reg;
  fwp_ctx_t r_next;

  function automatic logic is_read_op(input fwp_op_t op);
    return (op == OP_READ) || (op == OP_VERIFY);
  endfunction : is_read_op

  function automatic logic is_hv_pulse_op(input fwp_op_t op);
    return (op == OP_PROTECT) || (op == OP_UNPROTECT);
  endfunction : is_hv_pulse_op

  always_comb begin
    r_next               = r_reg;
    r_next.rsp_valid     = 1'b0;
    r_next.pins.reset_hv = TEMP_UNPROTECT_I;
    unique case (r_reg.state)
      ST_IDLE: begin
        if (REQ_VALID_I) begin
          r_next.op         = REQ_I.op;
          r_next.pins.addr  = REQ_I.addr;
          r_next.pins.dq_o  = REQ_I.wdata;
          r_next.pins.ce_n  = 1'b0;
          r_next.cnt        = CNT_ONE;
          r_next.state      = ST_SETUP;
          case (REQ_I.op)
            OP_WRITE: begin
              r_next.pins.dq_oe = 1'b1;
            end
            OP_PROTECT: begin
              r_next.pins.addr9_hv         = 1'b1;
              r_next.pins.oe_hv            = 1'b1;
              r_next.pins.addr[ADDR_BIT_6] = 1'b0;
              r_next.cnt                   = HV_CYC;
            end
            OP_VERIFY: begin
              r_next.pins.addr9_hv         = 1'b1;
              r_next.pins.addr[ADDR_BIT_1] = 1'b1;
              r_next.pins.addr[ADDR_BIT_0] = 1'b0;
              r_next.pins.addr[ADDR_BIT_6] = 1'b0;
              r_next.cnt                   = HV_CYC;
            end
            OP_UNPROTECT: begin
              // Caller is expected to have protected every sector first
              r_next.pins.addr9_hv         = 1'b1;
              r_next.pins.oe_hv            = 1'b1;
              r_next.pins.addr[ADDR_BIT_6] = 1'b1;
              r_next.cnt                   = HV_CYC;
            end
            default: begin
              r_next.op = OP_READ;
            end
          endcase
        end
      end
      ST_SETUP: begin
        // High voltage settles before any strobe moves
        if (r_reg.cnt == CNT_ONE) begin
          r_next.state = ST_STROBE;
          if (is_read_op(r_reg.op)) begin
            r_next.pins.oe_n = 1'b0;
            r_next.cnt       = ACC_CYC;
          end else begin
            r_next.pins.we_n = 1'b0;
            r_next.cnt       = is_hv_pulse_op(r_reg.op) ? WPP_CYC : WP_CYC;
          end
        end else begin
          r_next.cnt = r_reg.cnt - CNT_ONE;
        end
      end
      ST_STROBE: begin
        if (r_reg.cnt == CNT_ONE) begin
          r_next.pins.we_n = 1'b1;
          r_next.pins.oe_n = 1'b1;
          r_next.rsp_valid = 1'b1;
          if (is_read_op(r_reg.op)) begin
            r_next.rdata = FLASH_DQ_I;
          end
          r_next.cnt   = WPH_CYC;
          r_next.state = ST_RECOVER;
        end else begin
          r_next.cnt = r_reg.cnt - CNT_ONE;
        end
      end
      ST_RECOVER: begin
        // HV is held until after the strobe has risen
        r_next.pins.ce_n  = 1'b1;
        r_next.pins.dq_oe = 1'b0;
        r_next.pins.addr9_hv = 1'b0;
        r_next.pins.oe_hv = 1'b0;
        if (r_reg.cnt == CNT_ONE) begin
          r_next.state = ST_IDLE;
        end else begin
          r_next.cnt = r_reg.cnt - CNT_ONE;
        end
      end
    endcase
  end

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      r_reg <= CTX_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign REQ_READY_O      = (r_reg.state == ST_IDLE);
  assign RSP_VALID_O      = r_reg.rsp_valid;
  assign RSP_DATA_O       = r_reg.rdata;
  assign RSP_PROTECTED_O  = r_reg.rdata[DATA_BIT_0];
  assign FLASH_CE_N_O     = r_reg.pins.ce_n;
  assign FLASH_OE_N_O     = r_reg.pins.oe_n;
  assign FLASH_WE_N_O     = r_reg.pins.we_n;
  assign FLASH_OE_HV_O    = r_reg.pins.oe_hv;
  assign FLASH_ADDR9_HV_O = r_reg.pins.addr9_hv;
  assign FLASH_RESET_HV_O = r_reg.pins.reset_hv;
  assign FLASH_ADDR_O     = r_reg.pins.addr;
  assign FLASH_DQ_O       = r_reg.pins.dq_o;
  assign FLASH_DQ_OE_O    = r_reg.pins.dq_oe;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);

  sequence s_hv_pair;
    FLASH_ADDR9_HV_O && FLASH_OE_HV_O && FLASH_OE_N_O;
  endsequence

  sequence s_short_pulse;
    !FLASH_WE_N_O [*7] ##1 FLASH_WE_N_O;
  endsequence

  property p_write_gate;
    !FLASH_WE_N_O |-> !FLASH_CE_N_O && FLASH_OE_N_O && !FLASH_DQ_OE_O == (r_reg.op != OP_WRITE);
  endproperty
  a_write_gate: assert property (p_write_gate) else $error("write strobe without valid gating");

  property p_write_width;
    $fell(FLASH_WE_N_O) && !FLASH_OE_HV_O |-> s_short_pulse;
  endproperty
  a_write_width: assert property (p_write_width) else $error("write pulse width wrong");

  property p_no_contention;
    !FLASH_OE_N_O |-> !FLASH_DQ_OE_O && FLASH_WE_N_O;
  endproperty
  a_no_contention: assert property (p_no_contention) else $error("output enable low while driving");

  property p_temp_hold;
    TEMP_UNPROTECT_I |=> FLASH_RESET_HV_O;
  endproperty
  a_temp_hold: assert property (p_temp_hold) else $error("reset high voltage not held");

  property p_temp_release;
    !TEMP_UNPROTECT_I |=> !FLASH_RESET_HV_O;
  endproperty
  a_temp_release: assert property (p_temp_release) else $error("reset high voltage not released");

  property p_protect_hv;
    $fell(FLASH_WE_N_O) && (r_reg.op == OP_PROTECT) |-> s_hv_pair [*8] ##[1:20] (FLASH_WE_N_O && FLASH_ADDR9_HV_O);
  endproperty
  a_protect_hv: assert property (p_protect_hv) else $error("protect pulse without high voltage");

  property p_hv_settled;
    $fell(FLASH_WE_N_O) && FLASH_ADDR9_HV_O |-> $past(FLASH_ADDR9_HV_O, 8);
  endproperty
  a_hv_settled: assert property (p_hv_settled) else $error("high voltage not settled before pulse");

  property p_unprotect_setup;
    !FLASH_WE_N_O && (r_reg.op == OP_UNPROTECT) |->
      FLASH_ADDR9_HV_O && FLASH_OE_HV_O && !FLASH_CE_N_O && FLASH_ADDR_O[ADDR_BIT_6];
  endproperty
  a_unprotect_setup: assert property (p_unprotect_setup) else $error("chip unprotect pins wrong");

endmodule : fwp_host

/* File: rtl/fwp_pkg.sv */
package fwp_pkg;

  // ----------------------------------------------------------------
  // Widths and pin positions
  // ----------------------------------------------------------------
  localparam int ADDR_W     = 18;
  localparam int DATA_W     = 8;
  localparam int CNT_W      = 9;
  localparam int ADDR_BIT_0 = 0;
  localparam int ADDR_BIT_1 = 1;
  localparam int ADDR_BIT_6 = 6;
  localparam int DATA_BIT_0 = 0;

  typedef logic [CNT_W-1:0] fwp_cnt_t;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int T_CLK_PS       = 5000;
  localparam int T_WP_NS        = 35;
  localparam int T_WPH_NS       = 30;
  localparam int T_WPP_NS       = 100;
  localparam int T_ACC_NS       = 90;
  localparam int T_HV_SETTLE_NS = 1000;
  localparam int PS_PER_NS      = 1000;

  // Least times round up to whole cycles
  function automatic fwp_cnt_t fwp_cyc(input int t_ns);
    int c;
    c = (t_ns * PS_PER_NS + T_CLK_PS - 1) / T_CLK_PS;
    if (c < 1) c = 1;
    return fwp_cnt_t'(c);
  endfunction : fwp_cyc

  localparam fwp_cnt_t WP_CYC    = fwp_cyc(T_WP_NS);
  localparam fwp_cnt_t WPH_CYC   = fwp_cyc(T_WPH_NS);
  localparam fwp_cnt_t WPP_CYC   = fwp_cyc(T_WPP_NS);
  localparam fwp_cnt_t ACC_CYC   = fwp_cyc(T_ACC_NS);
  localparam fwp_cnt_t HV_CYC    = fwp_cyc(T_HV_SETTLE_NS);
  localparam fwp_cnt_t CNT_ONE   = 9'h001;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_READ,
    OP_WRITE,
    OP_PROTECT,
    OP_VERIFY,
    OP_UNPROTECT
  } fwp_op_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SETUP,
    ST_STROBE,
    ST_RECOVER
  } fwp_state_t;

  typedef struct packed {
    fwp_op_t                op;
    logic [ADDR_W-1:0]      addr;
    logic [DATA_W-1:0]      wdata;
  } fwp_req_t;

  typedef struct packed {
    logic                   ce_n;
    logic                   oe_n;
    logic                   we_n;
    logic                   oe_hv;
    logic                   addr9_hv;
    logic                   reset_hv;
    logic [ADDR_W-1:0]      addr;
    logic [DATA_W-1:0]      dq_o;
    logic                   dq_oe;
  } fwp_pins_t;

  typedef struct packed {
    fwp_state_t             state;
    fwp_op_t                op;
    fwp_cnt_t               cnt;
    fwp_pins_t              pins;
    logic [DATA_W-1:0]      rdata;
    logic                   rsp_valid;
  } fwp_ctx_t;

  localparam fwp_pins_t PINS_IDLE = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, oe_hv: 1'b0, addr9_hv: 1'b0,
                                      reset_hv: 1'b0, addr: '0, dq_o: '0, dq_oe: 1'b0};
  localparam fwp_ctx_t  CTX_RESET = '{state: ST_IDLE, op: OP_READ, cnt: '0, pins: PINS_IDLE,
                                      rdata: '0, rsp_valid: 1'b0};

endpackage : fwp_pkg

/* File: verif/fwp_flash_model.sv */
`timescale 1ns/1ps
module fwp_flash_model #(
  parameter logic [7:0] ID_CODE = 8'h5A // Arbitrary identification value
) (
  input  wire logic                       ce_n_i,
  input  wire logic                       oe_n_i,
  input  wire logic                       we_n_i,
  input  wire logic                       oe_hv_i,
  input  wire logic                       addr9_hv_i,
  input  wire logic                       reset_hv_i,
  input  wire logic [fwp_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [fwp_pkg::DATA_W-1:0] dq_i,
  input  wire logic                       dq_oe_i,
  output logic      [fwp_pkg::DATA_W-1:0] dq_o
);
  import fwp_pkg::*;
  // ------------------------------
  // Array and protection state
  // ------------------------------
  logic [7:0] mem [logic [ADDR_W-1:0]];
  logic [7:0] prot    = 8'h00;
  logic       id_mode = 1'b0;
  logic       armed   = 1'b0;
  int         seq     = 0;
  realtime    t_fall  = 0.0;
  logic [7:0] rd;
  wire  [2:0] sec     = addr_i[17:15];
  realtime    t_addr  = 0.0;
  logic       asleep  = 1'b0;

  // Sleep is invisible at the pins, so only this flag shows it
  always @(addr_i) t_addr = $realtime;
  always #1 asleep = ($realtime - t_addr) >= (T_ACC_NS + 30.0);

  always @(negedge we_n_i) begin
    t_fall = $realtime;
    armed  = !ce_n_i && oe_n_i;
  end

  // Work happens at the closing edge, so short strobes are simply dropped
  always @(posedge we_n_i) begin
    if (armed && ($realtime - t_fall) >= 5.0) begin
      if (oe_hv_i && addr9_hv_i) begin
        if (addr_i[ADDR_BIT_6]) prot = 8'h00;
        else prot[sec] = 1'b1;
      end else if (dq_i == 8'hF0) begin
        seq     = 0;
        id_mode = 1'b0;
      end else begin
        case (seq)
          0: seq = (dq_i == 8'hAA) ? 1 : 0;
          1: seq = (dq_i == 8'h55) ? 2 : 0;
          2: begin
            id_mode = (dq_i == 8'h90);
            seq     = (dq_i == 8'hA0) ? 3 : 0;
          end
          default: begin
            if (!prot[sec] || reset_hv_i) mem[addr_i] = rd & dq_i;
            seq = 0;
          end
        endcase
      end
    end
    armed = 1'b0;
  end

  always @* begin
    if (addr9_hv_i || id_mode) rd = addr_i[ADDR_BIT_1] ? {7'h00, prot[sec]} : ID_CODE;
    else rd = mem.exists(addr_i) ? mem[addr_i] : 8'hFF;
  end

  // Undriven bus shows the inverse so a stale byte never passes
  always @* begin
    if (dq_oe_i) dq_o = dq_i;
    else if (!ce_n_i && !oe_n_i) dq_o = rd;
    else dq_o = ~rd;
  end
endmodule : fwp_flash_model

/* File: verif/tb_fwp_host.sv */
`timescale 1ns/1ps
module tb_fwp_host;
  import fwp_pkg::*;
  localparam logic [7:0] ID_CODE = 8'h5A; // Arbitrary identification value
  logic              clk = 1'b0, rst = 1'b1, req_valid = 1'b0, temp_unp = 1'b0;
  fwp_req_t          req = '0;
  logic              ready, rsp_valid, rsp_prot, ce_n, oe_n, we_n, oe_hv, addr9_hv, reset_hv, dq_oe;
  logic [ADDR_W-1:0] addr, a, b;
  logic [DATA_W-1:0] rsp_data, dq_host, dq_bus, d, got;
  logic [2:0]        s;
  int                n_errors = 0, comparisons = 0;

  initial forever #2.5 clk = ~clk;

  fwp_host i_dut (.CLOCK_I(clk), .RST_I(rst), .REQ_VALID_I(req_valid), .REQ_I(req), .REQ_READY_O(ready),
    .RSP_VALID_O(rsp_valid), .RSP_DATA_O(rsp_data), .RSP_PROTECTED_O(rsp_prot), .TEMP_UNPROTECT_I(temp_unp),
    .FLASH_CE_N_O(ce_n), .FLASH_OE_N_O(oe_n), .FLASH_WE_N_O(we_n), .FLASH_OE_HV_O(oe_hv),
    .FLASH_ADDR9_HV_O(addr9_hv), .FLASH_RESET_HV_O(reset_hv), .FLASH_ADDR_O(addr), .FLASH_DQ_I(dq_bus),
    .FLASH_DQ_O(dq_host), .FLASH_DQ_OE_O(dq_oe));

  fwp_flash_model #(.ID_CODE(ID_CODE)) i_flash (.ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n),
    .oe_hv_i(oe_hv), .addr9_hv_i(addr9_hv), .reset_hv_i(reset_hv), .addr_i(addr), .dq_i(dq_host),
    .dq_oe_i(dq_oe), .dq_o(dq_bus));

  // ------------------------------
  // Checking and bus tasks
  // ------------------------------
  task automatic results;
    if (n_errors == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : check

  function automatic int lat_of(input fwp_op_t o);
    case (o)
      OP_WRITE:  return 2 + WP_CYC;
      OP_READ:   return 2 + ACC_CYC;
      OP_VERIFY: return 1 + HV_CYC + ACC_CYC;
      default:   return 1 + HV_CYC + WPP_CYC;
    endcase
  endfunction : lat_of

  function automatic logic [7:0] prog_val(input logic [7:0] old, input logic [7:0] nw);
    return old & nw;
  endfunction : prog_val

  // Bounded wait: a lost answer counts as a mismatch and ends the run
  task automatic op(input fwp_op_t o, input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] wd);
    int n;
    @(posedge clk);
    req_valid <= 1'b1;
    req       <= '{op: o, addr: ad, wdata: wd};
    @(posedge clk);
    req_valid <= 1'b0;
    // The taking edge ends cycle 0, so the cycle now running is 1
    n = 1;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (rsp_valid !== 1'b1 && n < 400);
    check(n, lat_of(o));
    got = rsp_data;
    check(ready, 1'b0);
    if (n >= 400) results();
    repeat (6) @(posedge clk);
    #1;
    check(ready, 1'b1);
    @(posedge clk);
  endtask : op

  task automatic wr3(input logic [7:0] third);
    op(OP_WRITE, 18'h00555, 8'hAA);
    op(OP_WRITE, 18'h002AA, 8'h55);
    op(OP_WRITE, 18'h00555, third);
  endtask : wr3

  task automatic prog(input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] wd);
    wr3(8'hA0);
    op(OP_WRITE, ad, wd);
  endtask : prog

  // ------------------------------
  // Main sequence
  // ------------------------------
  initial begin
    void'($urandom(60250));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    s = 3'($urandom_range(7));
    a = {s, 15'($urandom)};
    b = {s + 3'h1, 15'($urandom)};
    d = 8'($urandom_range(8'h7F));
    op(OP_READ, a, 8'h00);
    check(got, 8'hFF);
    check(i_flash.asleep, 1'b1);
    op(OP_PROTECT, {s, 15'h0000}, 8'h00);
    op(OP_VERIFY, {s, 15'($urandom)}, 8'h00);
    check(rsp_prot, 1'b1);
    op(OP_VERIFY, b, 8'h00);
    check(got, 8'h00);
    prog(a, d);
    op(OP_READ, a, 8'h00);
    check(got, 8'hFF);
    op(OP_WRITE, 18'h00555, 8'hAA);
    op(OP_WRITE, 18'h002AA, 8'h55);
    op(OP_WRITE, b, d);
    op(OP_READ, b, 8'h00);
    check(got, 8'hFF);
    @(posedge clk);
    temp_unp <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check(reset_hv, 1'b1);
    prog(a, d);
    op(OP_READ, a, 8'h00);
    check(got, prog_val(8'hFF, d));
    temp_unp <= 1'b0;
    prog(a, 8'h00);
    op(OP_READ, a, 8'h00);
    check(got, prog_val(8'hFF, d));
    wr3(8'h90);
    op(OP_READ, {s, 15'h0002}, 8'h00);
    check(got[0], 1'b1);
    op(OP_READ, {s, 15'h0000}, 8'h00);
    check(got, ID_CODE);
    op(OP_WRITE, 18'h00000, 8'hF0);
    op(OP_UNPROTECT, {s, 15'h0040}, 8'h00);
    wr3(8'h90);
    for (int i = 0; i < 8; i++) begin
      op(OP_READ, {3'(i), 15'h0002}, 8'h00);
      check(got, 8'h00);
    end
    op(OP_WRITE, 18'h00000, 8'hF0);
    for (int i = 0; i < 3; i++) begin
      b = {s, 15'($urandom)};
      d = 8'($urandom_range(8'h7F));
      prog(b, d);
      op(OP_READ, b, 8'h00);
      check(got, prog_val(8'hFF, d));
    end
    results();
  end
endmodule : tb_fwp_host
